// file: ufts_pkg.sv
// Shared constants and carrier types for the unimplemented floating-point trap sequencer.
package ufts_pkg;

  // Opcode fields of a line-1111 instruction word.
  localparam logic [3:0] OPC_FLINE = 4'hf;
  localparam logic [2:0] OPC_FP_CPID = 3'h1;
  localparam logic [2:0] OPC_FP_TYPE_MAX = 3'h5;

  // Effective-address mode field values.
  localparam logic [2:0] EAM_AN_IND = 3'h2;
  localparam logic [2:0] EAM_AN_POST = 3'h3;
  localparam logic [2:0] EAM_AN_PRE = 3'h4;
  localparam logic [2:0] EAM_AN_D16 = 3'h5;
  localparam logic [2:0] EAM_AN_IDX = 3'h6;
  localparam logic [2:0] EAM_EXT = 3'h7;
  localparam logic [2:0] EXT_ABS_W = 3'h0;
  localparam logic [2:0] EXT_ABS_L = 3'h1;
  localparam logic [2:0] EXT_PC_D16 = 3'h2;
  localparam logic [2:0] EXT_PC_IDX = 3'h3;
  localparam logic [31:0] PC_EXT_OFS = 32'h00000002;

  // Status word bit positions.
  localparam int SR_T1_BIT = 15;
  localparam int SR_T0_BIT = 14;
  localparam int SR_S_BIT = 13;

  // Frame layout: eight 16-bit words pushed as four longwords.
  localparam logic [3:0] FRAME_FMT_FP = 4'h4;
  localparam logic [11:0] FLINE_VEC_OFS = 12'h02c;
  localparam int FRAME_LWORDS = 4;
  localparam logic [31:0] FRAME_BYTES = 32'h00000010;
  localparam logic [31:0] LWORD_BYTES = 32'h00000004;

  // APB register byte offsets.
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_IRQ_STAT = 12'h004;
  localparam logic [11:0] REG_IRQ_CLR = 12'h008;
  localparam logic [11:0] REG_IRQ_EN = 12'h00c;
  localparam logic [11:0] REG_VBR = 12'h010;
  localparam logic [11:0] REG_COUNT = 12'h014;
  localparam logic [11:0] REG_STATE = 12'h018;
  localparam logic [31:0] CTRL_RST = 32'h00000001;
  localparam logic [31:0] VBR_RST = 32'h00000000;

  // Interrupt event bits.
  localparam int EV_W = 3;
  localparam int EV_FP_TRAP = 0;
  localparam int EV_AE_DRAIN = 1;
  localparam int EV_OTHER_FLINE = 2;

  // Sequencer states.
  typedef enum logic [3:0] {
    UFTS_IDLE, UFTS_DECODE, UFTS_DRAIN, UFTS_AE_WAIT, UFTS_LATCH,
    UFTS_LOAD, UFTS_PRIME, UFTS_PUSH, UFTS_VEC_REQ, UFTS_VEC_WAIT, UFTS_START
  } ufts_state_e;

  // Instruction handed over by the integer pipeline.
  typedef struct packed {
    logic valid;
    logic [15:0] opcode;
    logic [31:0] ext;
    logic [31:0] an;
    logic [31:0] xn;
    logic [31:0] pc;
    logic [31:0] next_pc;
    logic [3:0] size_bytes;
  } ufts_instr_s;

  // Request toward supervisor stack and vector memory.
  typedef struct packed {
    logic valid;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } ufts_mem_req_s;

  // Answer from memory.
  typedef struct packed {
    logic ready;
    logic [31:0] rdata;
  } ufts_mem_rsp_s;

  // APB slave request and answer.
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } ufts_apb_req_s;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ufts_apb_rsp_s;

endpackage

// file: ufts_frame_mem.sv
// Small frame staging memory with registered read data.
`timescale 1ns/10ps
module ufts_frame_mem #(
  parameter int DEPTH = 4,
  parameter int WIDTH = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic we,
  input wire logic [$clog2(DEPTH)-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  import ufts_pkg::*;

  // The frame needs at least as many words as it pushes.
  if (DEPTH < FRAME_LWORDS) begin : g_depth_chk
    $error("ufts_frame_mem depth too small for a frame.");
  end

  // All state of the memory.
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] words;
    logic [WIDTH-1:0] rdata;
  } ufts_fmem_s;

  ufts_fmem_s st;
  ufts_fmem_s next_st;

  ////////////////////////////////////////////////////////////////////////////
  // Read is registered so the pushed data come straight from a flop; a write
  // to the word being read shows one cycle later, which the sequencer allows.
  always_comb begin
    next_st = st;
    if (we) begin
      next_st.words[waddr] = wdata;
    end
    next_st.rdata = st.words[raddr];
  end

  // Register the state.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;
endmodule

// file: ufts_sequencer.sv
// Trap sequencer that routes floating-point opcodes to the line-1111 trap with a format 4 frame.
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/10ps
// What this block does
// (RULE1) Every legal floating-point opcode traps as unimplemented.
// (RULE2) Build eight-word format 4 frame before vectoring.
// (RULE3) Only floating-point opcodes get the format 4 frame.
// (RULE4) Partially decode and compute operand address first.
// (RULE5) Wait for earlier work and write-backs.
// (RULE6) Drain access error raises trap, marks pending.
// (RULE7) After handler return, start trap without re-executing.
// (RULE8) Latch status word, set supervisor, clear trace.
// (RULE9) Frame holds status, counters, vector offset, address.
// (RULE10) Address word uses the instruction's own mode.
// (RULE11) Predecrement stack, fetch vector, start handler.
module ufts_sequencer (
  input wire logic clk,
  input wire logic rst,
  input ufts_pkg::ufts_instr_s instr,
  output logic instr_ready,
  input wire logic earlier_busy,
  input wire logic wb_pending,
  input wire logic wb_acc_err,
  input wire logic ae_handler_done,
  input wire logic [15:0] status_word_in,
  input wire logic [31:0] ssp_in,
  output logic [15:0] status_word_out,
  output logic status_word_load,
  output logic [31:0] ssp_out,
  output logic ssp_load,
  output logic ae_trap,
  output logic ae_fp_pending,
  output logic other_fline_trap,
  output logic [31:0] handler_pc,
  output logic handler_start,
  output logic busy,
  output ufts_pkg::ufts_mem_req_s mem_req,
  input ufts_pkg::ufts_mem_rsp_s mem_rsp,
  input ufts_pkg::ufts_apb_req_s apb_req,
  output ufts_pkg::ufts_apb_rsp_s apb_rsp,
  output logic irq
);
  import ufts_pkg::*;

  localparam int IDXW = $clog2(FRAME_LWORDS);
  localparam logic [IDXW-1:0] LAST_IDX = IDXW'(FRAME_LWORDS - 1);

  // All state of the sequencer.
  typedef struct packed {
    ufts_state_e state;
    logic [15:0] opcode;
    logic [31:0] fault_pc;
    logic [31:0] next_pc;
    logic [31:0] ea;
    logic [15:0] sr_copy;
    logic [31:0] sp;
    logic [IDXW-1:0] idx;
    logic fp_pending;
    ufts_mem_req_s req;
    logic [15:0] sr_out;
    logic sr_load;
    logic [31:0] ssp;
    logic ssp_load;
    logic ae_trap;
    logic other_trap;
    logic [31:0] hpc;
    logic hstart;
    logic [31:0] ctrl;
    logic [EV_W-1:0] ev_stat;
    logic [EV_W-1:0] ev_en;
    logic [31:0] vbr;
    logic [31:0] count;
    logic [31:0] prdata;
    logic pslverr;
  } ufts_seq_s;

  ufts_seq_s st;
  ufts_seq_s next_st;

  logic fm_we;
  logic [IDXW-1:0] fm_waddr;
  logic [31:0] fm_wdata;
  logic [31:0] fm_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // A legal floating-point opcode: line 1111, coprocessor 1, a defined type.
  function automatic logic is_fp_op(input logic [15:0] op);
    is_fp_op = (op[15:12] == OPC_FLINE) && (op[11:9] == OPC_FP_CPID) && (op[8:6] <= OPC_FP_TYPE_MAX);
  endfunction

  // Sign-extend a 16-bit displacement.
  function automatic logic [31:0] sext16(input logic [15:0] d);
    sext16 = {{16{d[15]}}, d};
  endfunction

  // Sign-extend an 8-bit displacement.
  function automatic logic [31:0] sext8(input logic [7:0] d);
    sext8 = {{24{d[7]}}, d};
  endfunction

  // Operand address from the instruction's own mode; register and immediate
  // operands have no memory address, so the word reads zero for them.
  function automatic logic [31:0] ea_calc(input ufts_instr_s i);
    logic [31:0] pcx;
    pcx = i.pc + PC_EXT_OFS;
    case (i.opcode[5:3])
      EAM_AN_IND: ea_calc = i.an;
      EAM_AN_POST: ea_calc = i.an;
      EAM_AN_PRE: ea_calc = i.an - {28'h0000000, i.size_bytes};
      EAM_AN_D16: ea_calc = i.an + sext16(i.ext[15:0]);
      EAM_AN_IDX: ea_calc = i.an + i.xn + sext8(i.ext[7:0]);
      EAM_EXT: begin
        case (i.opcode[2:0])
          EXT_ABS_W: ea_calc = sext16(i.ext[15:0]);
          EXT_ABS_L: ea_calc = i.ext;
          EXT_PC_D16: ea_calc = pcx + sext16(i.ext[15:0]);
          EXT_PC_IDX: ea_calc = pcx + i.xn + sext8(i.ext[7:0]);
          default: ea_calc = 32'h00000000;
        endcase
      end
      default: ea_calc = 32'h00000000;
    endcase
  endfunction

  // One longword of the format 4 frame, lowest address first.
  function automatic logic [31:0] frame_word(input logic [IDXW-1:0] k, input ufts_seq_s s);
    case (k)
      IDXW'(0): frame_word = {s.sr_copy, s.next_pc[31:16]};
      IDXW'(1): frame_word = {s.next_pc[15:0], FRAME_FMT_FP, FLINE_VEC_OFS};
      IDXW'(2): frame_word = s.ea;
      default: frame_word = s.fault_pc;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Frame staging memory; the push reads it back word by word. The read
  // address is the index of the coming cycle, so the registered word already
  // stands in PRIME instead of trailing one longword behind.
  ufts_frame_mem #(
    .DEPTH(FRAME_LWORDS),
    .WIDTH(32)
  ) u_frame_mem (
    .clk(clk),
    .rst(rst),
    .we(fm_we),
    .waddr(fm_waddr),
    .wdata(fm_wdata),
    .raddr(next_st.idx),
    .rdata(fm_rdata)
  );

  // Frame words are written during the load state only.
  always_comb begin
    fm_we = (st.state == UFTS_LOAD);
    fm_waddr = st.idx;
    fm_wdata = frame_word(st.idx, st);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic for the sequencer and its registers.
  always_comb begin
    logic [EV_W-1:0] ev_set;
    logic apb_wr;
    ev_set = '0;
    next_st = st;
    next_st.sr_load = 1'b0;
    next_st.ssp_load = 1'b0;
    next_st.ae_trap = 1'b0;
    next_st.other_trap = 1'b0;
    next_st.hstart = 1'b0;
    apb_wr = apb_req.psel && apb_req.penable && apb_req.pwrite;

    case (st.state)
      // Accept an instruction when enabled and sort it.
      UFTS_IDLE: begin
        if (instr.valid && st.ctrl[0]) begin
          if (is_fp_op(instr.opcode)) begin // [RULE1] [RULE3]
            next_st.opcode = instr.opcode;
            next_st.fault_pc = instr.pc;
            next_st.next_pc = instr.next_pc;
            next_st.ea = ea_calc(instr); // [RULE4] [RULE10]
            next_st.state = UFTS_DECODE;
          end else if (instr.opcode[15:12] == OPC_FLINE) begin
            // Other line-1111 words take the ordinary trap path outside.
            next_st.other_trap = 1'b1; // [RULE3]
            ev_set[EV_OTHER_FLINE] = 1'b1;
          end
        end
      end
      // Address is now held; exception work may proceed.
      UFTS_DECODE: begin
        next_st.state = UFTS_DRAIN; // [RULE4]
      end
      // Hold off until earlier instructions and write-backs are done.
      UFTS_DRAIN: begin
        if (wb_acc_err) begin
          next_st.ae_trap = 1'b1; // [RULE6]
          next_st.fp_pending = 1'b1; // [RULE6]
          ev_set[EV_AE_DRAIN] = 1'b1;
          next_st.state = UFTS_AE_WAIT;
        end else if (!earlier_busy && !wb_pending) begin
          next_st.state = UFTS_LATCH; // [RULE5]
        end
      end
      // The access error handler runs; its return resumes this trap directly.
      UFTS_AE_WAIT: begin
        if (ae_handler_done) begin
          next_st.fp_pending = 1'b0;
          next_st.state = UFTS_LATCH; // [RULE7]
        end
      end
      // Copy the status word, then go supervisor with tracing off.
      UFTS_LATCH: begin
        next_st.sr_copy = status_word_in; // [RULE8]
        next_st.sr_out = status_word_in;
        next_st.sr_out[SR_S_BIT] = 1'b1; // [RULE8]
        next_st.sr_out[SR_T1_BIT] = 1'b0; // [RULE8]
        next_st.sr_out[SR_T0_BIT] = 1'b0; // [RULE8]
        next_st.sr_load = 1'b1;
        next_st.sp = ssp_in - FRAME_BYTES; // [RULE11]
        next_st.idx = '0;
        next_st.state = UFTS_LOAD;
      end
      // Fill the staging memory one longword per cycle.
      UFTS_LOAD: begin
        if (st.idx == LAST_IDX) begin
          next_st.idx = '0;
          next_st.state = UFTS_PRIME; // [RULE2] [RULE9]
        end else begin
          next_st.idx = st.idx + IDXW'(1);
        end
      end
      // Registered read needs one cycle before the word can be pushed.
      UFTS_PRIME: begin
        next_st.req.valid = 1'b1;
        next_st.req.we = 1'b1;
        next_st.req.addr = st.sp + 32'({st.idx, 2'b00});
        next_st.req.wdata = fm_rdata;
        next_st.state = UFTS_PUSH;
      end
      // Hold each write until memory takes it.
      UFTS_PUSH: begin
        if (mem_rsp.ready) begin
          next_st.req.valid = 1'b0;
          if (st.idx == LAST_IDX) begin
            next_st.ssp = st.sp; // [RULE11]
            next_st.ssp_load = 1'b1;
            next_st.state = UFTS_VEC_REQ;
          end else begin
            next_st.idx = st.idx + IDXW'(1);
            next_st.state = UFTS_PRIME;
          end
        end
      end
      // Fetch the line-1111 vector.
      UFTS_VEC_REQ: begin
        next_st.req.valid = 1'b1;
        next_st.req.we = 1'b0;
        next_st.req.addr = st.vbr + {20'h00000, FLINE_VEC_OFS}; // [RULE11]
        next_st.req.wdata = 32'h00000000;
        next_st.state = UFTS_VEC_WAIT;
      end
      UFTS_VEC_WAIT: begin
        if (mem_rsp.ready) begin
          next_st.req.valid = 1'b0;
          next_st.hpc = mem_rsp.rdata;
          next_st.state = UFTS_START;
        end
      end
      // Start the handler at the fetched address.
      UFTS_START: begin
        next_st.hstart = 1'b1; // [RULE11]
        next_st.count = st.count + 32'h00000001;
        ev_set[EV_FP_TRAP] = 1'b1;
        next_st.state = UFTS_IDLE;
      end
      default: begin
        next_st.state = UFTS_IDLE;
      end
    endcase

    // APB writes take effect in the access phase.
    if (apb_wr) begin
      case (apb_req.paddr)
        REG_CTRL: next_st.ctrl = apb_req.pwdata;
        REG_IRQ_EN: next_st.ev_en = apb_req.pwdata[EV_W-1:0];
        REG_VBR: next_st.vbr = apb_req.pwdata;
        REG_IRQ_CLR: next_st.ev_stat = st.ev_stat & ~apb_req.pwdata[EV_W-1:0];
        default: next_st.ev_stat = next_st.ev_stat;
      endcase
    end
    // A new event beats a clear in the same cycle.
    next_st.ev_stat = next_st.ev_stat | ev_set;

    // Read data and error are prepared in the setup phase.
    if (apb_req.psel && !apb_req.penable) begin
      next_st.pslverr = 1'b0;
      case (apb_req.paddr)
        REG_CTRL: next_st.prdata = st.ctrl;
        REG_IRQ_STAT: next_st.prdata = {{(32-EV_W){1'b0}}, st.ev_stat};
        REG_IRQ_CLR: next_st.prdata = 32'h00000000;
        REG_IRQ_EN: next_st.prdata = {{(32-EV_W){1'b0}}, st.ev_en};
        REG_VBR: next_st.prdata = st.vbr;
        REG_COUNT: next_st.prdata = st.count;
        REG_STATE: next_st.prdata = {27'h0000000, st.fp_pending, st.state};
        default: begin
          next_st.prdata = 32'h00000000;
          next_st.pslverr = 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register the whole state.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
      st.state <= UFTS_IDLE;
      st.ctrl <= CTRL_RST;
      st.vbr <= VBR_RST;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs; zero-wait APB, so pready is constant high.
  always_comb begin
    instr_ready = (st.state == UFTS_IDLE);
    status_word_out = st.sr_out;
    status_word_load = st.sr_load;
    ssp_out = st.ssp;
    ssp_load = st.ssp_load;
    ae_trap = st.ae_trap;
    ae_fp_pending = st.fp_pending; // [RULE6]
    other_fline_trap = st.other_trap;
    handler_pc = st.hpc;
    handler_start = st.hstart;
    busy = (st.state != UFTS_IDLE);
    mem_req = st.req;
    apb_rsp.pready = 1'b1;
    apb_rsp.pslverr = st.pslverr;
    apb_rsp.prdata = st.prdata;
    irq = |(st.ev_stat & st.ev_en);
  end
endmodule

// file: ufts_assertions.sv
// Port-level temporal checks for the trap sequencer.
`timescale 1ns/10ps
module ufts_assertions
  import ufts_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input ufts_pkg::ufts_instr_s instr,
  input wire logic instr_ready,
  input wire logic earlier_busy,
  input wire logic wb_pending,
  input wire logic ae_handler_done,
  input wire logic [31:0] ssp_in,
  input wire logic [15:0] status_word_out,
  input wire logic status_word_load,
  input wire logic [31:0] ssp_out,
  input wire logic ssp_load,
  input wire logic ae_trap,
  input wire logic ae_fp_pending,
  input wire logic other_fline_trap,
  input wire logic [31:0] handler_pc,
  input wire logic handler_start,
  input wire logic busy,
  input ufts_pkg::ufts_mem_req_s mem_req,
  input ufts_pkg::ufts_mem_rsp_s mem_rsp
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // A legal floating-point opcode offered to an idle sequencer.
  logic fp_take;
  assign fp_take = instr.valid && instr_ready && instr.opcode[15:9] == {OPC_FLINE, OPC_FP_CPID}
    && instr.opcode[8:6] <= OPC_FP_TYPE_MAX;
  ////////////////////////////////////////////////////////////////////////////
  a_fp_not_other: assert property (fp_take |=> !other_fline_trap)
    else $error("fp opcode raised the plain line-1111 trap");
  a_other_no_frame: assert property (other_fline_trap |-> !busy && !mem_req.valid)
    else $error("plain line-1111 trap built a frame");
  a_fmt_word: assert property (mem_req.valid && mem_req.we && mem_req.addr == ssp_in - 32'h0000000c
    |-> mem_req.wdata[15:0] == {FRAME_FMT_FP, FLINE_VEC_OFS})
    else $error("frame format word wrong");
  // Load is two edges after the drain decision, so drain inputs must be idle then.
  a_drain_hold: assert property (status_word_load |-> !$past(earlier_busy, 2) && !$past(wb_pending, 2))
    else $error("trap sequence began before drain completed");
  a_ae_marks: assert property (ae_trap |-> ae_fp_pending)
    else $error("access error frame lacks pending mark");
  a_pend_no_push: assert property (ae_fp_pending |-> !mem_req.valid && !status_word_load)
    else $error("frame pushed while access error pending");
  a_ae_resume: assert property (ae_fp_pending && ae_handler_done |-> ##2 status_word_load)
    else $error("trap did not resume after handler return");
  a_sr_bits: assert property (status_word_load |-> status_word_out[SR_S_BIT]
    && !status_word_out[SR_T1_BIT] && !status_word_out[SR_T0_BIT])
    else $error("status word not supervisor with trace cleared");
  a_ssp_predec: assert property (ssp_load |-> ssp_out == ssp_in - FRAME_BYTES)
    else $error("stack pointer not predecremented by frame size");
  a_vec_start: assert property (handler_start |-> handler_pc == $past(mem_rsp.rdata, 2))
    else $error("handler address differs from fetched vector");
  c_ae: cover property (ae_trap);
  c_start: cover property (handler_start);
  c_other: cover property (other_fline_trap);
  c_stall: cover property (mem_req.valid && !mem_rsp.ready);
endmodule
bind ufts_sequencer ufts_assertions i_ufts_assertions (.clk(clk), .rst(rst), .instr(instr),
  .instr_ready(instr_ready), .earlier_busy(earlier_busy), .wb_pending(wb_pending),
  .ae_handler_done(ae_handler_done), .ssp_in(ssp_in), .status_word_out(status_word_out),
  .status_word_load(status_word_load), .ssp_out(ssp_out), .ssp_load(ssp_load), .ae_trap(ae_trap),
  .ae_fp_pending(ae_fp_pending), .other_fline_trap(other_fline_trap), .handler_pc(handler_pc),
  .handler_start(handler_start), .busy(busy), .mem_req(mem_req), .mem_rsp(mem_rsp));

// file: ufts_mem_model.sv
// Supervisor stack and vector memory responder with adjustable wait states.
`timescale 1ns/10ps
module ufts_mem_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] dly,
  input ufts_pkg::ufts_mem_req_s req,
  output ufts_pkg::ufts_mem_rsp_s rsp
);
  import ufts_pkg::*;
  logic [63:0] wq[$]; // Accepted writes as {address, data}.
  logic [1:0] cnt; // Wait states spent on the current request.
  logic [31:0] noise; // Read data is junk outside the ready cycle.
  ////////////////////////////////////////////////////////////////////////////
  // Ready rises after dly waits and drops once the handshake edge passes.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rsp <= '0;
      cnt <= 2'h0;
      noise <= 32'h0;
    end else begin
      noise <= noise + 32'h00009e37;
      if (rsp.ready && req.valid) begin
        // Handshake edge: a write lands here and nowhere else.
        if (req.we) wq.push_back({req.addr, req.wdata});
        rsp <= '{1'b0, ~noise};
        cnt <= 2'h0;
      end else if (req.valid && cnt >= dly) begin
        // Vector reads return the inverted address so the bench can predict them.
        rsp <= '{1'b1, ~req.addr};
      end else begin
        rsp <= '{1'b0, noise};
        if (req.valid) cnt <= cnt + 2'h1;
      end
    end
  end
endmodule

// file: unimpl_fp_trap_sequencer_tb.sv
// Self-checking bench for the trap sequencer with a behavioural frame model.
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
module unimpl_fp_trap_sequencer_tb;
  import ufts_pkg::*;
  logic clk = 1'b0, rst = 1'b1, earlier_busy = 1'b0, wb_pending = 1'b0, wb_acc_err = 1'b0;
  logic ae_handler_done = 1'b0, instr_ready, status_word_load, ssp_load, ae_trap, ae_fp_pending;
  logic other_fline_trap, handler_start, busy, irq;
  logic [15:0] status_word_in = 16'h0000, status_word_out, sw_seen, lf = 16'h0018;
  logic [31:0] ssp_in = 32'h0, ssp_out, ssp_seen, handler_pc, vbr, q;
  logic [1:0] dly = 2'h0;
  logic e;
  ufts_instr_s instr = '0;
  ufts_mem_req_s mem_req;
  ufts_mem_rsp_s mem_rsp;
  ufts_apb_req_s apb_req = '0;
  ufts_apb_rsp_s apb_rsp;
  int errors = 0, n_checks = 0, cyc = 0, n_oth = 0, n_ae = 0, n_fp = 0;
  logic [5:0] modes [11] = '{6'h00, 6'h11, 6'h1a, 6'h23, 6'h2c, 6'h35, 6'h38, 6'h39, 6'h3a, 6'h3b, 6'h3c};
  ufts_sequencer i_ufts_sequencer (.clk(clk), .rst(rst), .instr(instr), .instr_ready(instr_ready),
    .earlier_busy(earlier_busy), .wb_pending(wb_pending), .wb_acc_err(wb_acc_err),
    .ae_handler_done(ae_handler_done), .status_word_in(status_word_in), .ssp_in(ssp_in),
    .status_word_out(status_word_out), .status_word_load(status_word_load), .ssp_out(ssp_out),
    .ssp_load(ssp_load), .ae_trap(ae_trap), .ae_fp_pending(ae_fp_pending),
    .other_fline_trap(other_fline_trap), .handler_pc(handler_pc), .handler_start(handler_start),
    .busy(busy), .mem_req(mem_req), .mem_rsp(mem_rsp), .apb_req(apb_req), .apb_rsp(apb_rsp), .irq(irq));
  ufts_mem_model i_mem (.clk(clk), .rst(rst), .dly(dly), .req(mem_req), .rsp(mem_rsp));
  initial forever #50 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  // Pulse monitors and the hang guard; a trap takes well under 60 cycles.
  always @(posedge clk) begin
    cyc++;
    if (status_word_load === 1'b1) sw_seen <= status_word_out;
    if (ssp_load === 1'b1) ssp_seen <= ssp_out;
    if (other_fline_trap === 1'b1) n_oth++;
    if (ae_trap === 1'b1) n_ae++;
    if (cyc > 5000) begin
      errors++;
      close_out();
    end
  end
  function automatic logic [31:0] rnd();
    repeat (2) lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return {lf, lf ^ 16'ha5c3};
  endfunction
  // Reference operand address from mode and register fields.
  function automatic logic [31:0] ea_of(input ufts_instr_s x);
    logic [31:0] d16, d8;
    d16 = {{16{x.ext[15]}}, x.ext[15:0]};
    d8 = {{24{x.ext[7]}}, x.ext[7:0]};
    case (x.opcode[5:3])
      3'h2, 3'h3: return x.an;
      3'h4: return x.an - {28'h0, x.size_bytes};
      3'h5: return x.an + d16;
      3'h6: return x.an + x.xn + d8;
      3'h7: case (x.opcode[2:0])
        3'h0: return d16;
        3'h1: return x.ext;
        3'h2: return x.pc + PC_EXT_OFS + d16;
        3'h3: return x.pc + PC_EXT_OFS + x.xn + d8;
        default: return 32'h0;
      endcase
      default: return 32'h0;
    endcase
  endfunction
  // One APB transfer; held until pready is seen at a rising edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    do @(posedge clk); while (apb_rsp.pready !== 1'b1);
    q = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    apb_req <= '0;
  endtask
  // Offer one opcode, optionally fault the drain, then check the frame.
  task automatic trap(input logic [15:0] op, input logic ae);
    ufts_instr_s x;
    logic [31:0] r;
    logic [63:0] w, ex [4];
    int k;
    x = '{1'b1, op, rnd(), rnd(), rnd(), rnd() & 32'hfffffffe, rnd(), 4'h0};
    x.size_bytes = lf[3:0];
    r = rnd();
    ex[0] = {r[31:16], 16'h7ff0, r[15:0], x.next_pc[31:16]};
    ex[1] = {r[31:16], 16'h7ff4, x.next_pc[15:0], FRAME_FMT_FP, FLINE_VEC_OFS};
    ex[2] = {r[31:16], 16'h7ff8, ea_of(x)};
    ex[3] = {r[31:16], 16'h7ffc, x.pc};
    @(posedge clk);
    instr <= x;
    status_word_in <= r[15:0];
    ssp_in <= {r[31:16], 16'h8000};
    earlier_busy <= 1'b1;
    wb_pending <= r[4];
    dly <= r[6:5];
    @(posedge clk);
    instr.valid <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK(i_mem.wq.size(), 0)
    `CHK(busy, 1'b1)
    k = n_ae;
    earlier_busy <= 1'b0;
    wb_pending <= 1'b0;
    if (ae) begin
      wb_acc_err <= 1'b1;
      @(posedge clk);
      wb_acc_err <= 1'b0;
      repeat (3) @(posedge clk);
      `CHK(n_ae, k + 1)
      `CHK(ae_fp_pending, 1'b1)
      `CHK(i_mem.wq.size(), 0)
      ae_handler_done <= 1'b1;
      @(posedge clk);
      ae_handler_done <= 1'b0;
    end
    k = 0;
    while (handler_start !== 1'b1 && k < 300) begin
      @(posedge clk);
      k++;
    end
    n_fp++;
    `CHK(handler_pc, ~(vbr + 32'h0000002c))
    `CHK(sw_seen, (r[15:0] | 16'h2000) & 16'h3fff)
    `CHK(ssp_seen, {r[31:16], 16'h7ff0})
    `CHK(i_mem.wq.size(), 4)
    for (k = 0; k < 4; k++) begin
      w = i_mem.wq.pop_front();
      `CHK(w, ex[k])
    end
  endtask
  // A line-1111 opcode that is not floating point takes the plain trap.
  task automatic other(input logic [15:0] op);
    int k;
    k = n_oth;
    @(posedge clk);
    instr <= '{1'b1, op, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 4'h0};
    @(posedge clk);
    instr.valid <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK(n_oth, k + 1)
    `CHK(busy, 1'b0)
    `CHK(i_mem.wq.size(), 0)
  endtask
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Registers, every addressing mode but address register direct, a faulted drain, plain traps, interrupts.
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, REG_CTRL, 32'h0);
    `CHK(q, CTRL_RST)
    apb(1'b0, REG_VBR, 32'h0);
    `CHK(q, VBR_RST)
    apb(1'b0, 12'h020, 32'h0);
    `CHK({e, q}, 33'h100000000)
    vbr = rnd() & 32'hfffffc00;
    apb(1'b1, REG_VBR, vbr);
    apb(1'b0, REG_VBR, 32'h0);
    `CHK(q, vbr)
    apb(1'b1, REG_IRQ_EN, 32'h7);
    for (int i = 0; i < 11; i++) trap({OPC_FLINE, OPC_FP_CPID, 3'(i % 6), modes[i]}, i == 3);
    other({OPC_FLINE, 3'h2, 9'h000});
    other({OPC_FLINE, OPC_FP_CPID, 3'h6, 6'h00});
    apb(1'b0, REG_COUNT, 32'h0);
    `CHK(q, 32'(n_fp))
    apb(1'b0, REG_IRQ_STAT, 32'h0);
    `CHK(q, 32'h7)
    `CHK(irq, 1'b1)
    apb(1'b1, REG_IRQ_EN, 32'h0);
    @(posedge clk);
    `CHK(irq, 1'b0)
    apb(1'b1, REG_IRQ_CLR, 32'h7);
    apb(1'b0, REG_IRQ_STAT, 32'h0);
    `CHK(q, 32'h0)
    close_out();
  end
endmodule
